// ---- verilog/shc_top.v ----
// sample-and-hold trigger, timing, flag and register control
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "shc_defines.vh"
module shc_top #(
  parameter INT_PULSE_CYC = `SHC_CYC_DN(`SHC_INT_PULSE_NS),
  parameter FAST_SLOT_CYC = `SHC_CYC_DN(`SHC_FAST_SLOT_NS),
  parameter NORM_SLOT_CYC = `SHC_CYC_DN(`SHC_NORM_SLOT_NS),
  parameter RES_W = 14
) (
  clk,
  reset,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  trigger_input_a,
  trigger_input_b,
  external_timing_clock,
  adc_averaging,
  adc_done_a,
  adc_done_b,
  adc_result,
  hold_channel_a,
  hold_channel_b,
  conv_req_a,
  conv_req_b,
  conv_loc_a,
  conv_loc_b,
  gain_trim_sel,
  priority_slot_a,
  discharge_a,
  discharge_b,
  irq_a,
  irq_b
);
  input wire clk;
  input wire reset;
  input wire [`SHC_ADDR_W-1:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire trigger_input_a;
  input wire trigger_input_b;
  input wire external_timing_clock;
  input wire adc_averaging;
  input wire adc_done_a;
  input wire adc_done_b;
  input wire [RES_W-1:0] adc_result;
  output reg hold_channel_a;
  output reg hold_channel_b;
  output reg conv_req_a;
  output reg conv_req_b;
  output reg [4:0] conv_loc_a;
  output reg [4:0] conv_loc_b;
  output reg [1:0] gain_trim_sel;
  output reg priority_slot_a;
  output reg discharge_a;
  output reg discharge_b;
  output reg irq_a;
  output reg irq_b;

  reg [15:0] hold_control_register;
  reg [1:0] internal_trigger_register;
  reg [1:0] converter_status_register;
  reg [15:0] result_a_reg;
  reg [15:0] result_b_reg;
  reg [1:0] trig_a_sync_reg;
  reg [1:0] trig_b_sync_reg;
  reg [2:0] ext_sync_reg;
  reg [7:0] int_cnt_a_reg;
  reg [7:0] int_cnt_b_reg;
  reg [15:0] slot_cnt_reg;
  reg [1:0] round_pend_reg;
  reg samp_a_d_reg;
  reg samp_b_d_reg;
  reg trig_a_d_reg;
  reg trig_b_d_reg;
  reg [31:0] rd_mux;
  reg [15:0] slot_len;

  wire bus_req;
  wire bus_go;
  wire wr_go;
  wire en_a;
  wire en_b;
  wire dual;
  wire ext_tick;
  wire int_pulse_a;
  wire int_pulse_b;
  wire eff_trig_a;
  wire eff_trig_b;
  wire samp_a;
  wire samp_b;
  wire fall_a;
  wire fall_b;
  wire rise_a;
  wire rise_b;
  wire done_a_ev;
  wire done_b_ev;
  wire single_done;
  wire [1:0] clr_stat;
  wire fire_a;
  wire fire_b;

  assign en_a = hold_control_register[`SHC_B_EN_A];
  assign en_b = hold_control_register[`SHC_B_EN_B];
  assign dual = hold_control_register[`SHC_B_DUAL];

  // bus: a request is taken on the edge where waitrequest is seen low
  assign bus_req = avs_read | avs_write;
  assign bus_go = bus_req & ~avs_waitrequest;
  assign wr_go = avs_write & ~avs_waitrequest;
  assign fire_a = wr_go && (avs_address == `SHC_OFS_ITRIG) && avs_writedata[`SHC_B_FIRE_A];
  assign fire_b = wr_go && (avs_address == `SHC_OFS_ITRIG) && avs_writedata[`SHC_B_FIRE_B];
  assign clr_stat = (wr_go && (avs_address == `SHC_OFS_STAT)) ?
                    avs_writedata[1:0] : 2'h0;

  // trigger and timing clock pins pass two flops before use
  assign ext_tick = ext_sync_reg[1] & ~ext_sync_reg[2];

  // internal pulse generators
  assign int_pulse_a = (int_cnt_a_reg != 8'h00);
  assign int_pulse_b = (int_cnt_b_reg != 8'h00);

  // trigger routing per mode
  assign eff_trig_a = en_a & (internal_trigger_register[`SHC_B_ITRIG_A] ?
                      int_pulse_a : trig_a_sync_reg[1]);
  assign eff_trig_b = en_b & (dual ?
                      (internal_trigger_register[`SHC_B_ITRIG_B] ?
                       int_pulse_b : trig_b_sync_reg[1]) :
                      (internal_trigger_register[`SHC_B_ITRIG_A] ?
                       int_pulse_a : trig_a_sync_reg[1]));
  assign rise_a = eff_trig_a & ~trig_a_d_reg;
  assign rise_b = eff_trig_b & ~trig_b_d_reg;

  shc_stop_timer #(
    .CNT_W(8)
  ) u_timer_a (
    .clk(clk),
    .reset(reset),
    .trig(eff_trig_a),
    .ext_tick(ext_tick),
    .clk_sel(hold_control_register[`SHC_B_CLKSEL]),
    .code(hold_control_register[`SHC_F_CODE]),
    .sampling(samp_a)
  );

  shc_stop_timer #(
    .CNT_W(8)
  ) u_timer_b (
    .clk(clk),
    .reset(reset),
    .trig(eff_trig_b),
    .ext_tick(ext_tick),
    .clk_sel(hold_control_register[`SHC_B_CLKSEL]),
    .code(hold_control_register[`SHC_F_CODE]),
    .sampling(samp_b)
  );

  assign fall_a = samp_a_d_reg & ~samp_a;
  assign fall_b = samp_b_d_reg & ~samp_b;
  assign done_a_ev = conv_req_a & adc_done_a;
  assign done_b_ev = conv_req_b & adc_done_b;
  // last pending enabled channel finishing closes a single-mode round
  assign single_done = (round_pend_reg != 2'h0) &&
                       ((round_pend_reg & ~{done_b_ev, done_a_ev}) == 2'h0);

  always @* begin
    slot_len = (hold_control_register[`SHC_B_FAST] && !adc_averaging) ?
               FAST_SLOT_CYC[15:0] : NORM_SLOT_CYC[15:0];
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `SHC_OFS_CTRL: rd_mux = {16'h0000, hold_control_register};
      `SHC_OFS_ITRIG: rd_mux = {30'h0000_0000, internal_trigger_register};
      `SHC_OFS_STAT: rd_mux = {30'h0000_0000, converter_status_register};
      `SHC_OFS_RES_A: rd_mux = {16'h0000, result_a_reg};
      `SHC_OFS_RES_B: rd_mux = {16'h0000, result_b_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  function [15:0] justify;
    input [RES_W-1:0] raw;
    input left;
    begin
      if (left) begin
        justify = {raw, 2'b00};
      end else begin
        justify = {{(16-RES_W){raw[RES_W-1]}}, raw};
      end
    end
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      hold_control_register <= `SHC_CTRL_RESET;
      internal_trigger_register <= 2'h0;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      if (wr_go && avs_address == `SHC_OFS_CTRL) begin
        hold_control_register <= avs_writedata[15:0] & `SHC_CTRL_WMASK;
      end
      if (wr_go && avs_address == `SHC_OFS_ITRIG) begin
        internal_trigger_register <= avs_writedata[1:0];
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_a_sync_reg <= 2'h0;
      trig_b_sync_reg <= 2'h0;
      ext_sync_reg <= 3'h0;
      int_cnt_a_reg <= 8'h00;
      int_cnt_b_reg <= 8'h00;
      trig_a_d_reg <= 1'b0;
      trig_b_d_reg <= 1'b0;
      samp_a_d_reg <= 1'b0;
      samp_b_d_reg <= 1'b0;
    end else begin
      trig_a_sync_reg <= {trig_a_sync_reg[0], trigger_input_a};
      trig_b_sync_reg <= {trig_b_sync_reg[0], trigger_input_b};
      ext_sync_reg <= {ext_sync_reg[1:0], external_timing_clock};
      if (fire_a) begin
        int_cnt_a_reg <= INT_PULSE_CYC[7:0];
      end else if (int_pulse_a) begin
        int_cnt_a_reg <= int_cnt_a_reg - 8'h01;
      end
      if (fire_b) begin
        int_cnt_b_reg <= INT_PULSE_CYC[7:0];
      end else if (int_pulse_b) begin
        int_cnt_b_reg <= int_cnt_b_reg - 8'h01;
      end
      trig_a_d_reg <= eff_trig_a;
      trig_b_d_reg <= eff_trig_b;
      samp_a_d_reg <= samp_a;
      samp_b_d_reg <= samp_b;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_channel_a <= 1'b0;
      hold_channel_b <= 1'b0;
      conv_req_a <= 1'b0;
      conv_req_b <= 1'b0;
      conv_loc_a <= `SHC_LOC_A;
      conv_loc_b <= `SHC_LOC_B;
      gain_trim_sel <= `SHC_GAIN_UNITY;
      result_a_reg <= 16'h0000;
      result_b_reg <= 16'h0000;
      round_pend_reg <= 2'h0;
    end else begin
      hold_channel_a <= samp_a;
      hold_channel_b <= samp_b;
      conv_loc_a <= `SHC_LOC_A;
      conv_loc_b <= `SHC_LOC_B;
      gain_trim_sel <= `SHC_GAIN_UNITY;
      if (fall_a) begin
        conv_req_a <= 1'b1;
      end else if (done_a_ev) begin
        conv_req_a <= 1'b0;
      end
      if (fall_b) begin
        conv_req_b <= 1'b1;
      end else if (done_b_ev) begin
        conv_req_b <= 1'b0;
      end
      if (done_a_ev) begin
        result_a_reg <= justify(adc_result, hold_control_register[`SHC_B_JUST_A]);
      end
      if (done_b_ev) begin
        result_b_reg <= justify(adc_result, hold_control_register[`SHC_B_JUST_B]);
      end
      // a new single-mode round starts on the shared trigger rise
      if (!dual && (rise_a || rise_b)) begin
        round_pend_reg <= {en_b, en_a};
      end else if (single_done) begin
        round_pend_reg <= 2'h0;
      end else begin
        round_pend_reg <= round_pend_reg & ~{done_b_ev, done_a_ev};
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      converter_status_register <= 2'h0;
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end else begin
      // set wins over a software clear in the same cycle
      if (dual ? done_a_ev : single_done) begin
        converter_status_register[`SHC_B_DONE_A] <= 1'b1;
      end else if (clr_stat[`SHC_B_DONE_A]) begin
        converter_status_register[`SHC_B_DONE_A] <= 1'b0;
      end
      if (dual && en_a && en_b && done_b_ev) begin
        converter_status_register[`SHC_B_DONE_B] <= 1'b1;
      end else if (clr_stat[`SHC_B_DONE_B]) begin
        converter_status_register[`SHC_B_DONE_B] <= 1'b0;
      end
      irq_a <= converter_status_register[`SHC_B_DONE_A] &
               hold_control_register[`SHC_B_IRQEN_A];
      irq_b <= converter_status_register[`SHC_B_DONE_B] &
               hold_control_register[`SHC_B_IRQEN_B] & dual;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      discharge_a <= 1'b0;
      discharge_b <= 1'b0;
    end else begin
      if (rise_a) begin
        discharge_a <= 1'b0;
      end else if (done_a_ev && hold_control_register[`SHC_B_DIS_A]) begin
        discharge_a <= 1'b1;
      end
      if (rise_b) begin
        discharge_b <= 1'b0;
      end else if (done_b_ev && hold_control_register[`SHC_B_DIS_B]) begin
        discharge_b <= 1'b1;
      end
    end
  end

  // slot clock for channel a: a one-cycle grant each interval while enable a is set
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      slot_cnt_reg <= 16'h0000;
      priority_slot_a <= 1'b0;
    end else begin
      priority_slot_a <= 1'b0;
      if (slot_cnt_reg + 16'h0001 >= slot_len) begin
        slot_cnt_reg <= 16'h0000;
        priority_slot_a <= en_a;
      end else begin
        slot_cnt_reg <= slot_cnt_reg + 16'h0001;
      end
    end
  end
endmodule // shc_top

// ---- inc/shc_defines.vh ----
// constants for the sample-and-hold trigger control block
// Contract
// - two identical channels, internal or external trigger
// - internal trigger makes its own sample pulse
// - sample while pulse high, stop on fall
// - after pulse low, request conversion of held voltage
// - each channel has its own enable bit
// - single mode: trigger a samples both channels
// - single mode: flag a after all enabled convert
// - single mode: enable a gates, one source field; the code gates channel b with enable b instead
// - dual mode: channels triggered fully independently
// - dual mode: each channel sets own flag
// - flag b used only dual with both enabled
// - results go to buffer locations 23 and 24
// - fast mode grants channel a slot every 125us
// - averaging voids the slot guarantee
// - clock select: peripheral 0, external 1
// - external clock: stop after code-dependent edge count
// - peripheral clock: stop after code-dependent time
// - discharge from conversion end to next trigger rise
// - conversions always use the unity gain trim
// - peripheral stop codes: table of delays
// - external stop codes: 21 to 35 edges
// - justify bit selects left or sign-extended right
`ifndef SHC_DEFINES_VH
`define SHC_DEFINES_VH

`define SHC_CLK_NS 100
`define SHC_CYC_UP(t) (((t) + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_CYC_DN(t) ((t) / `SHC_CLK_NS)

`define SHC_ADDR_W 5
`define SHC_OFS_CTRL 5'h00
`define SHC_OFS_ITRIG 5'h04
`define SHC_OFS_STAT 5'h08
`define SHC_OFS_RES_A 5'h0C
`define SHC_OFS_RES_B 5'h10

`define SHC_CTRL_RESET 16'h0000
`define SHC_CTRL_WMASK 16'hFF7F
`define SHC_B_EN_A 0
`define SHC_B_IRQEN_A 1
`define SHC_B_JUST_A 2
`define SHC_B_CLKSEL 3
`define SHC_B_EN_B 4
`define SHC_B_IRQEN_B 5
`define SHC_B_JUST_B 6
`define SHC_B_DUAL 8
`define SHC_B_DIS_A 9
`define SHC_B_DIS_B 10
`define SHC_B_FAST 11
`define SHC_F_CODE 15:12

`define SHC_B_ITRIG_A 0
`define SHC_B_ITRIG_B 1
`define SHC_B_FIRE_A 4
`define SHC_B_FIRE_B 5
`define SHC_B_DONE_A 0
`define SHC_B_DONE_B 1

`define SHC_LOC_A 5'h17
`define SHC_LOC_B 5'h18
`define SHC_GAIN_UNITY 2'h0

`define SHC_INT_PULSE_NS 3000
`define SHC_FAST_SLOT_NS 125000
`define SHC_NORM_SLOT_NS 250000

`define SHC_T_C4 300
`define SHC_T_C5 350
`define SHC_T_C6 450
`define SHC_T_C7 550
`define SHC_T_C8 750
`define SHC_T_C9 1000
`define SHC_T_C10 1500
`define SHC_T_C11 1750
`define SHC_T_C12 2000
`define SHC_T_C13 2500
`define SHC_T_C14 4000
`define SHC_T_C15 5000
`define SHC_EXT_BASE 20
`define SHC_CODE_FIRST_TIMED 4'h4

`endif

// ---- verilog/shc_stop_timer.v ----
// per-channel sample window: ends on trigger fall or after a coded delay
`timescale 1ns/1ps
`include "shc_defines.vh"
module shc_stop_timer #(
  parameter CNT_W = 8
) (
  clk,
  reset,
  trig,
  ext_tick,
  clk_sel,
  code,
  sampling
);
  input wire clk;
  input wire reset;
  input wire trig;
  input wire ext_tick;
  input wire clk_sel;
  input wire [3:0] code;
  output reg sampling;

  reg trig_d_reg;
  reg timed_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [31:0] limit_full;
  wire [CNT_W-1:0] limit;
  wire rise;
  wire tick;

  assign rise = trig & ~trig_d_reg;
  assign tick = clk_sel ? ext_tick : 1'b1;
  // counts stay far below the counter range, so the cut is on purpose
  assign limit = limit_full[CNT_W-1:0];

  always @* begin
    case (code)
      4'h4: limit_full = `SHC_CYC_UP(`SHC_T_C4);
      4'h5: limit_full = `SHC_CYC_UP(`SHC_T_C5);
      4'h6: limit_full = `SHC_CYC_UP(`SHC_T_C6);
      4'h7: limit_full = `SHC_CYC_UP(`SHC_T_C7);
      4'h8: limit_full = `SHC_CYC_UP(`SHC_T_C8);
      4'h9: limit_full = `SHC_CYC_UP(`SHC_T_C9);
      4'hA: limit_full = `SHC_CYC_UP(`SHC_T_C10);
      4'hB: limit_full = `SHC_CYC_UP(`SHC_T_C11);
      4'hC: limit_full = `SHC_CYC_UP(`SHC_T_C12);
      4'hD: limit_full = `SHC_CYC_UP(`SHC_T_C13);
      4'hE: limit_full = `SHC_CYC_UP(`SHC_T_C14);
      4'hF: limit_full = `SHC_CYC_UP(`SHC_T_C15);
      default: limit_full = 32'h0000_0000;
    endcase
    if (clk_sel) begin
      limit_full = `SHC_EXT_BASE + {28'h000_0000, code};
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_d_reg <= 1'b0;
      timed_reg <= 1'b0;
      cnt_reg <= {CNT_W{1'b0}};
      sampling <= 1'b0;
    end else begin
      trig_d_reg <= trig;
      if (rise) begin
        sampling <= 1'b1;
        cnt_reg <= {CNT_W{1'b0}};
        // reserved peripheral codes behave as code zero
        timed_reg <= clk_sel ? (code != 4'h0) : (code >= `SHC_CODE_FIRST_TIMED);
      end else if (sampling && timed_reg) begin
        if (tick) begin
          if (cnt_reg + 1'b1 >= limit) begin
            sampling <= 1'b0;
          end
          cnt_reg <= cnt_reg + 1'b1;
        end
      end else if (sampling && !trig) begin
        sampling <= 1'b0;
      end
    end
  end
endmodule // shc_stop_timer

// ---- tb/shc_chk.sv ----
// port checker for the sample-and-hold control block
`timescale 1ns/1ps
module shc_chk (
  input wire clk,
  input wire reset,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire trigger_input_a,
  input wire adc_done_a,
  input wire adc_done_b,
  input wire hold_channel_a,
  input wire hold_channel_b,
  input wire conv_req_a,
  input wire conv_req_b,
  input wire [4:0] conv_loc_a,
  input wire [4:0] conv_loc_b,
  input wire [1:0] gain_trim_sel,
  input wire priority_slot_a,
  input wire discharge_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("bus request not answered");
  a_conv_drop_a: assert property (conv_req_a && adc_done_a |=> !conv_req_a)
    else $error("conversion request a stays after done");
  a_conv_drop_b: assert property (conv_req_b && adc_done_b |=> !conv_req_b)
    else $error("conversion request b stays after done");
  a_hold_to_conv: assert property ($fell(hold_channel_a) |-> ##[0:2] conv_req_a)
    else $error("no conversion request after sampling ended");
  a_hold_to_conv_b: assert property ($fell(hold_channel_b) |-> ##[0:2] conv_req_b)
    else $error("no conversion request b after sampling ended");
  a_hold_end_fall: assert property ($fell(trigger_input_a) |-> ##[0:6] !hold_channel_a)
    else $error("sampling continues after trigger fall");
  a_disch_clear: assert property ($rose(hold_channel_a) |=> !discharge_a)
    else $error("discharge still active while sampling");
  a_slot_pulse: assert property (priority_slot_a |=> !priority_slot_a)
    else $error("slot pulse longer than one cycle");
  a_loc_fixed: assert property (conv_loc_a == 5'h17 && conv_loc_b == 5'h18)
    else $error("buffer location wrong");
  a_gain_unity: assert property (gain_trim_sel == 2'h0)
    else $error("gain trim not unity");
endmodule // shc_chk

bind shc_top shc_chk i_shc_chk (.clk(clk), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .trigger_input_a(trigger_input_a), .adc_done_a(adc_done_a), .adc_done_b(adc_done_b),
  .hold_channel_a(hold_channel_a), .hold_channel_b(hold_channel_b), .conv_req_a(conv_req_a),
  .conv_req_b(conv_req_b), .conv_loc_a(conv_loc_a), .conv_loc_b(conv_loc_b),
  .gain_trim_sel(gain_trim_sel), .priority_slot_a(priority_slot_a), .discharge_a(discharge_a));

// ---- tb/shc_adc_model.sv ----
// converter controller model: serves held channels one at a time
`timescale 1ns/1ps
module shc_adc_model (
  input wire clk,
  input wire reset,
  input wire slow,
  input wire conv_req_a,
  input wire conv_req_b,
  output logic adc_done_a,
  output logic adc_done_b,
  output logic [13:0] adc_result
);
  int cnt;
  logic busy, ch;
  logic [13:0] last, r;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      busy <= 1'b0;
      ch <= 1'b0;
      last <= 14'h0000;
      adc_done_a <= 1'b0;
      adc_done_b <= 1'b0;
      adc_result <= 14'h3FFF;
    end else begin
      adc_done_a <= 1'b0;
      adc_done_b <= 1'b0;
      // result bus is only valid with a done pulse
      adc_result <= ~last;
      if (cnt != 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        r = 14'($urandom);
        adc_result <= r;
        last <= r;
        adc_done_a <= !ch;
        adc_done_b <= ch;
        busy <= 1'b0;
        cnt <= 2;
      end else if (conv_req_a || conv_req_b) begin
        busy <= 1'b1;
        ch <= !conv_req_a;
        cnt <= slow ? 20 : 1;
      end
    end
  end
endmodule // shc_adc_model

// ---- tb/shc_tb_top.sv ----
// self-checking bench for the sample-and-hold control block
`timescale 1ns/1ps
module shc_tb_top;
  localparam int FAST = 20;
  localparam int NORM = 40;
  localparam int PT[12] = '{3, 4, 5, 6, 8, 10, 15, 18, 20, 25, 40, 50};
  localparam logic [15:0] RC[7] = '{16'h0013, 16'h0053, 16'h0012, 16'h0737, 16'h0131,
    16'h0130, 16'h0001};
  localparam logic [5:0] IT[7] = '{6'h11, 6'h00, 6'h00, 6'h00, 6'h22, 6'h00, 6'h00};
  localparam logic [1:0] MK[7] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h0, 2'h2, 2'h2};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic trigger_input_a = 1'b0;
  logic trigger_input_b = 1'b0;
  logic external_timing_clock = 1'b0;
  logic adc_averaging = 1'b0;
  logic slow = 1'b0;
  logic da = 1'b0;
  logic db = 1'b0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, adc_done_a, adc_done_b, hold_channel_a, hold_channel_b;
  logic conv_req_a, conv_req_b, priority_slot_a, discharge_a, discharge_b, irq_a, irq_b;
  logic [13:0] adc_result, raw_a, raw_b;
  logic [4:0] conv_loc_a, conv_loc_b;
  logic [1:0] gain_trim_sel;
  int num_errors = 0;
  int tests_run = 0;
  int nd = 0, hw = 0, wl = 0, sc = 0, gap = 0;

  always #50 clk = ~clk;
  always #170 external_timing_clock = ~external_timing_clock;

  shc_top #(.INT_PULSE_CYC(30), .FAST_SLOT_CYC(FAST), .NORM_SLOT_CYC(NORM)) i_shc_top (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_input_a(trigger_input_a),
    .trigger_input_b(trigger_input_b), .external_timing_clock(external_timing_clock),
    .adc_averaging(adc_averaging), .adc_done_a(adc_done_a), .adc_done_b(adc_done_b),
    .adc_result(adc_result), .hold_channel_a(hold_channel_a), .hold_channel_b(hold_channel_b),
    .conv_req_a(conv_req_a), .conv_req_b(conv_req_b), .conv_loc_a(conv_loc_a),
    .conv_loc_b(conv_loc_b), .gain_trim_sel(gain_trim_sel), .priority_slot_a(priority_slot_a),
    .discharge_a(discharge_a), .discharge_b(discharge_b), .irq_a(irq_a), .irq_b(irq_b));

  shc_adc_model i_shc_adc_model (.clk(clk), .reset(reset), .slow(slow),
    .conv_req_a(conv_req_a), .conv_req_b(conv_req_b), .adc_done_a(adc_done_a),
    .adc_done_b(adc_done_b), .adc_result(adc_result));

  // sampling width, captured results, conversion count and slot spacing
  always @(posedge clk) begin
    hw <= hold_channel_a ? hw + 1 : 0;
    if (!hold_channel_a && hw != 0) wl <= hw;
    if (adc_done_a) raw_a <= adc_result;
    if (adc_done_b) raw_b <= adc_result;
    if (adc_done_a || adc_done_b) nd <= nd + 1;
    sc <= priority_slot_a ? 0 : sc + 1;
    if (priority_slot_a) gap <= sc + 1;
  end

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t value got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t pin got %b exp %b", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    chk_pin(avs_waitrequest, 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] jst(input logic [13:0] r, input logic l);
    return l ? {16'h0, r, 2'b00} : {16'h0, {2{r[13]}}, r};
  endfunction

  // one trigger round; expectations come from the bench's own reading of the rules
  task automatic round(input logic [15:0] c, input logic [5:0] it, input logic [1:0] m,
                       input int len);
    logic du, ca, cb, fa, fb;
    int n0, k;
    du = c[8];
    ca = c[0] & (m[0] | it[4]);
    cb = c[4] & (du ? (m[1] | it[5]) : (m[0] | it[4]));
    fa = du ? ca : (ca | cb);
    fb = du & c[0] & cb;
    n0 = nd;
    bus(1'b1, 5'h00, {16'h0, c}, q);
    bus(1'b1, 5'h04, {26'h0, it}, q);
    trigger_input_a <= m[0];
    trigger_input_b <= m[1];
    for (k = 0; k < 800; k++) begin
      @(posedge clk);
      // trigger stands exactly len cycles
      if (k == len - 1) begin
        trigger_input_a <= 1'b0;
        trigger_input_b <= 1'b0;
      end
      if (k == 5) chk_pin(hold_channel_b, cb);
      if (k > len && nd == n0 + ca + cb) break;
      if (nd == n0 + 1 && ca && cb && !du) chk_pin(irq_a, 1'b0);
    end
    chk_reg(nd - n0, ca + cb);
    repeat (4) @(posedge clk);
    if (ca) da = c[9];
    if (cb) db = c[10];
    chk_pin(irq_a, fa & c[1]);
    chk_pin(irq_b, fb & c[5]);
    chk_pin(discharge_a, da);
    chk_pin(discharge_b, db);
    bus(1'b0, 5'h08, 32'h0, q);
    chk_reg(q, {30'h0, fb, fa});
    bus(1'b0, 5'h0C, 32'h0, q);
    if (ca) chk_reg(q, jst(raw_a, c[2]));
    bus(1'b0, 5'h10, 32'h0, q);
    if (cb) chk_reg(q, jst(raw_b, c[6]));
    bus(1'b1, 5'h08, 32'h3, q);
    bus(1'b0, 5'h08, 32'h0, q);
    chk_reg(q, 32'h0);
    chk_pin(irq_a, 1'b0);
    repeat (NORM) @(posedge clk);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #2500000;
    num_errors++;
    test_done;
  end

  initial begin
    void'($urandom(32'h3778dcdc));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_reg(conv_loc_a, 32'h17);
    chk_reg(conv_loc_b, 32'h18);
    chk_reg(gain_trim_sel, 32'h0);
    bus(1'b0, 5'h00, 32'h0, q);
    chk_reg(q, 32'h0);
    bus(1'b1, 5'h00, 32'hFFFF, q);
    bus(1'b0, 5'h00, 32'h0, q);
    chk_reg(q, 32'hFF7F);
    bus(1'b1, 5'h14, 32'hFFFF, q);
    bus(1'b0, 5'h14, 32'h0, q);
    chk_reg(q, 32'h0);
    bus(1'b1, 5'h00, 32'h0, q);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      slow <= (i == 0);
      round(RC[i], IT[i], MK[i], 10);
    end
    $display("test modes done");
    for (int c = 0; c < 16; c++) begin
      round({c[3:0], 12'h101}, 6'h00, 2'h1, 60);
      chk_reg(wl, c < 4 ? 60 : PT[c - 4]);
    end
    for (int c = 1; c < 16; c += 14) begin
      round({c[3:0], 12'h109}, 6'h00, 2'h1, 150);
      chk_pin(wl >= (20 + c) * 34 / 10 - 5 && wl <= (20 + c) * 34 / 10 + 5, 1'b1);
    end
    $display("test timing done");
    bus(1'b1, 5'h00, 32'h0801, q);
    repeat (3 * FAST + 5) @(posedge clk);
    chk_reg(gap, FAST);
    adc_averaging <= 1'b1;
    repeat (3 * NORM + 5) @(posedge clk);
    chk_reg(gap, NORM);
    adc_averaging <= 1'b0;
    bus(1'b1, 5'h00, 32'h0001, q);
    repeat (3 * NORM + 5) @(posedge clk);
    chk_reg(gap, NORM);
    $display("test slots done");
    test_done;
  end
endmodule // shc_tb_top
